// ### design/epd_partial_refresh_pll_temp_cmds.sv
// Command decoder for partial refresh, waveform tables, frame clock and
// temperature sensing of an electrophoretic display driver.
// Assumes frame memory answers pix_x_o/pix_y_o in the same cycle, and that
// an external I2C engine serves the sensor write request.
`timescale 1ns/100ps

// What this block does
// - Partial refresh drives pixels from memory and tables.
// - Only window updates; outside uses common table.
// - Busy output low while refresh runs.
// - Partial refresh accepted only while not busy.
// - Follow bit in B/W mode: equal pixels use common table.
// - Follow bit clear: data-dependent tables only.
// - Codes 20h-24h load the five tables.
// - PLL command sets frame rate fields.
// - Each divider step halves the frame rate.
// - Internal sensor value read when select clear.
// - External 11-bit reading split over two bytes.
// - Calibration bit 7 selects sensor, default internal.
// - Offset field decodes as signed four bits.
// - Attribute bits 7:6 give I2C byte count.
// - Attribute gives address bits and pointer.
// - High then low data byte follow attribute.
// - Sensor write only after power-on command.
module epd_partial_refresh_pll_temp_cmds (
  // Clock, reset and clock enable.
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  // Host byte port.
  input  wire logic        host_stb_i,
  input  wire logic        host_cd_i,
  input  wire logic        host_rw_i,
  input  wire logic [7:0]  host_data_i,
  output logic      [7:0]  host_rd_data_o,
  output logic             host_rd_valid_o,
  // Status and panel configuration.
  output logic             busy_n_o,
  input  wire logic        bw_mode_i,
  input  wire logic [8:0]  h_res_i,
  input  wire logic [8:0]  v_res_i,
  // Frame memory scan and waveform selection.
  input  wire logic        pix_new_i,
  input  wire logic        pix_old_i,
  output logic      [8:0]  pix_x_o,
  output logic      [8:0]  pix_y_o,
  output logic             pix_valid_o,
  output logic      [2:0]  pix_table_o,
  output logic             frame_tick_o,
  // Waveform table read port.
  input  wire logic [2:0]  lut_rd_table_i,
  input  wire logic [3:0]  lut_rd_index_i,
  output logic      [7:0]  lut_rd_data_o,
  // Temperature sources and settings.
  input  wire logic [7:0]  internal_temp_value_i,
  input  wire logic [10:0] ext_temp_i,
  output logic             external_sensor_select_o,
  output logic      [3:0]  temperature_offset_o,
  // External sensor write request.
  output logic             sensor_wr_req_o,
  output logic      [2:0]  sensor_wr_bytes_o,
  output logic      [2:0]  sensor_addr_bits_o,
  output logic      [2:0]  sensor_pointer_o,
  output logic      [7:0]  sensor_write_high_byte_o,
  output logic      [7:0]  sensor_write_low_byte_o
);

  // ==========================================================================
  // Declarations
  logic [7:0]                  cmd_r;
  logic                        cmd_ok_r;
  logic [4:0]                  pidx_r;
  logic                        powered_r;
  logic                        follow_en_r;
  logic [8:0]                  x_start_r;
  logic [8:0]                  y_start_r;
  logic [8:0]                  w_r;
  logic [8:0]                  l_r;
  logic [7:0]                  attr_r;
  logic [7:0]                  lut_mem_r [epd_cmd_pkg::LUT_COUNT]
                                         [epd_cmd_pkg::LUT_DEPTH];
  logic [5:0]                  freq_r;
  logic [1:0]                  div_r;
  logic [31:0]                 acc_r;
  logic [31:0]                 inc_raw;
  logic [31:0]                 inc_nxt;
  logic [32:0]                 acc_sum;
  epd_cmd_pkg::refresh_type    rf_state_r;
  logic                        scan_act_r;
  logic [7:0]                  temp_hi_r;
  logic [7:0]                  temp_lo_r;
  logic [7:0]                  temp_adj;
  logic                        in_area;
  logic [9:0]                  x_end;
  logic [9:0]                  y_end;
  epd_cmd_pkg::table_type      pix_sel;
  logic                        wr_cmd;
  logic                        wr_prm;
  logic                        rd_prm;
  logic                        refresh_go;
  logic                        lut_cmd;
  logic [2:0]                  lut_slot;

  // ==========================================================================
  // Host byte classification
  // Select low marks a command byte, high a parameter; direction low is a
  // write and high a read.
  assign wr_cmd  = ce_i && host_stb_i && !host_cd_i && !host_rw_i;
  assign wr_prm  = ce_i && host_stb_i && host_cd_i && !host_rw_i;
  assign rd_prm  = ce_i && host_stb_i && host_cd_i && host_rw_i;
  assign lut_cmd = (cmd_r >= epd_cmd_pkg::CMD_LUT_FIRST) &&
                   (cmd_r <= epd_cmd_pkg::CMD_LUT_LAST);
  assign lut_slot = 3'(cmd_r - epd_cmd_pkg::CMD_LUT_FIRST);
  // The refresh starts when the last window byte of an accepted command lands.
  assign refresh_go = wr_prm && cmd_ok_r &&
                      (cmd_r == epd_cmd_pkg::CMD_PARTIAL_REFRESH) &&
                      (pidx_r == epd_cmd_pkg::PRM_L_LO);

  // ==========================================================================
  // Command register and parameter index
  // A partial refresh sent while busy is dropped together with its bytes.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cmd_r    <= 8'h00;
      cmd_ok_r <= 1'b0;
      pidx_r   <= epd_cmd_pkg::PRM_FIRST;
    end else if (wr_cmd) begin
      cmd_r    <= host_data_i;
      cmd_ok_r <= (host_data_i != epd_cmd_pkg::CMD_PARTIAL_REFRESH) ||
                  busy_n_o;
      pidx_r   <= epd_cmd_pkg::PRM_FIRST;
    end else if ((wr_prm || rd_prm) && pidx_r != epd_cmd_pkg::PRM_SAT) begin
      pidx_r   <= pidx_r + 5'h01;
    end
  end

  // ==========================================================================
  // Power state
  // Either power-on command arms the external sensor write path.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      powered_r <= 1'b0;
    end else if (wr_cmd && (host_data_i == epd_cmd_pkg::CMD_POWER_ON ||
                 host_data_i == epd_cmd_pkg::CMD_POWER_ON_MEASURE)) begin
      powered_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Partial refresh window
  // The low three bits of the horizontal start are forced to zero, so a
  // misaligned start from the host snaps down to a byte boundary.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      follow_en_r <= 1'b0;
      x_start_r   <= 9'h000;
      y_start_r   <= 9'h000;
      w_r         <= 9'h000;
      l_r         <= 9'h000;
    end else if (wr_prm && cmd_ok_r &&
                 cmd_r == epd_cmd_pkg::CMD_PARTIAL_REFRESH) begin
      case (pidx_r)
        epd_cmd_pkg::PRM_FIRST: begin
          follow_en_r  <= host_data_i[epd_cmd_pkg::DFV_BIT];
          x_start_r[8] <= host_data_i[epd_cmd_pkg::HI_BIT];
        end
        epd_cmd_pkg::PRM_X_LO:
          x_start_r[7:0] <= {host_data_i[7:3], 3'h0};
        epd_cmd_pkg::PRM_Y_HI: y_start_r[8]   <= host_data_i[epd_cmd_pkg::HI_BIT];
        epd_cmd_pkg::PRM_Y_LO: y_start_r[7:0] <= host_data_i;
        epd_cmd_pkg::PRM_W_HI: w_r[8]         <= host_data_i[epd_cmd_pkg::HI_BIT];
        epd_cmd_pkg::PRM_W_LO: w_r[7:0]       <= host_data_i;
        epd_cmd_pkg::PRM_L_HI: l_r[8]         <= host_data_i[epd_cmd_pkg::HI_BIT];
        epd_cmd_pkg::PRM_L_LO: l_r[7:0]       <= host_data_i;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Waveform table storage
  // Bytes fill the selected table in arrival order; surplus bytes are
  // dropped rather than wrapping, so a long load never corrupts entry 0.
  always_ff @(posedge clk_i) begin
    if (wr_prm && lut_cmd && pidx_r < epd_cmd_pkg::LUT_LIMIT) begin
      lut_mem_r[lut_slot][pidx_r[3:0]] <= host_data_i;
    end
  end

  // Registered read port for the waveform generator.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      lut_rd_data_o <= 8'h00;
    end else if (ce_i) begin
      if (lut_rd_table_i < 3'(epd_cmd_pkg::LUT_COUNT)) begin
        lut_rd_data_o <= lut_mem_r[lut_rd_table_i][lut_rd_index_i];
      end else begin
        lut_rd_data_o <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // Frame clock settings
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      freq_r <= epd_cmd_pkg::FREQ_RST;
      div_r  <= epd_cmd_pkg::DIV_RST;
    end else if (wr_prm && cmd_r == epd_cmd_pkg::CMD_PLL &&
                 pidx_r == epd_cmd_pkg::PRM_FIRST) begin
      freq_r <= host_data_i[epd_cmd_pkg::FREQ_MSB:0];
      div_r  <= host_data_i[epd_cmd_pkg::DIV_MSB:epd_cmd_pkg::DIV_LSB];
    end
  end

  // Codes below 32 step the rate up from the base, codes from 32 step it
  // down; the divider then halves it once per step by shifting.
  always_comb begin
    if (!freq_r[5]) begin
      inc_raw = epd_cmd_pkg::INC_BASE +
                32'(freq_r[4:0]) * epd_cmd_pkg::INC_STEP;
    end else begin
      inc_raw = epd_cmd_pkg::INC_BASE -
                (32'(freq_r[4:0]) + 32'd1) * epd_cmd_pkg::INC_STEP;
    end
    inc_nxt = inc_raw >> div_r;
  end

  assign acc_sum = {1'b0, acc_r} + {1'b0, inc_nxt};

  // Phase accumulator; its carry is the frame tick.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      acc_r        <= 32'h0000_0000;
      frame_tick_o <= 1'b0;
    end else if (ce_i) begin
      acc_r        <= acc_sum[31:0];
      frame_tick_o <= acc_sum[32];
    end
  end

  // ==========================================================================
  // Refresh sequencer
  // The scan waits for a frame tick so each refresh starts on a frame edge.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rf_state_r <= epd_cmd_pkg::RF_IDLE;
      busy_n_o   <= 1'b1;
      scan_act_r <= 1'b0;
      pix_x_o    <= 9'h000;
      pix_y_o    <= 9'h000;
    end else if (ce_i) begin
      case (rf_state_r)
        epd_cmd_pkg::RF_IDLE: begin
          if (refresh_go) begin
            busy_n_o   <= 1'b0;
            rf_state_r <= epd_cmd_pkg::RF_WAIT;
          end
        end
        epd_cmd_pkg::RF_WAIT: begin
          if (frame_tick_o) begin
            pix_x_o    <= 9'h000;
            pix_y_o    <= 9'h000;
            scan_act_r <= 1'b1;
            rf_state_r <= epd_cmd_pkg::RF_SCAN;
          end
        end
        epd_cmd_pkg::RF_SCAN: begin
          if (pix_x_o + 9'h001 < h_res_i) begin
            pix_x_o <= pix_x_o + 9'h001;
          end else if (pix_y_o + 9'h001 < v_res_i) begin
            pix_x_o <= 9'h000;
            pix_y_o <= pix_y_o + 9'h001;
          end else begin
            scan_act_r <= 1'b0;
            busy_n_o   <= 1'b1;
            rf_state_r <= epd_cmd_pkg::RF_IDLE;
          end
        end
        default: begin
          scan_act_r <= 1'b0;
          busy_n_o   <= 1'b1;
          rf_state_r <= epd_cmd_pkg::RF_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Pixel waveform selection
  // End bounds are one bit wider so a window reaching the panel edge does
  // not wrap and empty itself.
  assign x_end   = {1'b0, x_start_r} + {1'b0, w_r};
  assign y_end   = {1'b0, y_start_r} + {1'b0, l_r};
  assign in_area = (pix_x_o >= x_start_r) && ({1'b0, pix_x_o} < x_end) &&
                   (pix_y_o >= y_start_r) && ({1'b0, pix_y_o} < y_end);

  pixel_waveform_select u_select (
    .in_area_i   (in_area),
    .follow_en_i (follow_en_r),
    .bw_mode_i   (bw_mode_i),
    .new_i       (pix_new_i),
    .old_i       (pix_old_i),
    .table_o     (pix_sel)
  );

  // The table code lags the address by one cycle.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pix_valid_o <= 1'b0;
      pix_table_o <= 3'h0;
    end else if (ce_i) begin
      pix_valid_o <= scan_act_r;
      pix_table_o <= pix_sel;
    end
  end

  // ==========================================================================
  // Temperature settings
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      external_sensor_select_o <= epd_cmd_pkg::TSE_RST;
      temperature_offset_o     <= epd_cmd_pkg::OFFSET_RST;
    end else if (wr_prm && cmd_r == epd_cmd_pkg::CMD_TEMP_CAL &&
                 pidx_r == epd_cmd_pkg::PRM_FIRST) begin
      external_sensor_select_o <= host_data_i[epd_cmd_pkg::TSE_BIT];
      temperature_offset_o     <= host_data_i[epd_cmd_pkg::OFFSET_MSB:0];
    end
  end

  // Offset sign-extends from four bits, giving -8 to +7.
  assign temp_adj = internal_temp_value_i +
                    {{4{temperature_offset_o[3]}}, temperature_offset_o};

  // The reading is captured at the command byte so the two returned bytes
  // always belong to the same sample.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      temp_hi_r <= 8'h00;
      temp_lo_r <= 8'h00;
    end else if (wr_cmd && host_data_i == epd_cmd_pkg::CMD_TEMP_READ) begin
      if (external_sensor_select_o) begin
        temp_hi_r <= ext_temp_i[10:3];
        temp_lo_r <= {ext_temp_i[2:0], 5'h00};
      end else begin
        temp_hi_r <= temp_adj;
        temp_lo_r <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // Host read answers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      host_rd_data_o  <= 8'h00;
      host_rd_valid_o <= 1'b0;
    end else if (ce_i) begin
      host_rd_valid_o <= rd_prm;
      if (rd_prm && cmd_r == epd_cmd_pkg::CMD_TEMP_READ &&
          pidx_r == epd_cmd_pkg::PRM_FIRST) begin
        host_rd_data_o <= temp_hi_r;
      end else if (rd_prm && cmd_r == epd_cmd_pkg::CMD_TEMP_READ &&
                   pidx_r == epd_cmd_pkg::PRM_SECOND) begin
        host_rd_data_o <= temp_lo_r;
      end else begin
        host_rd_data_o <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // External sensor write
  // The request fires on the low data byte; before any power-on command the
  // bytes and attribute fields still reach the outputs but no request is raised.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      attr_r                   <= 8'h00;
      sensor_write_high_byte_o <= 8'h00;
      sensor_write_low_byte_o  <= 8'h00;
      sensor_wr_req_o          <= 1'b0;
      sensor_wr_bytes_o        <= 3'h1;
      sensor_addr_bits_o       <= 3'h0;
      sensor_pointer_o         <= 3'h0;
    end else if (ce_i) begin
      sensor_wr_req_o <= 1'b0;
      if (wr_prm && cmd_r == epd_cmd_pkg::CMD_TEMP_WRITE) begin
        case (pidx_r)
          epd_cmd_pkg::PRM_FIRST: attr_r <= host_data_i;
          epd_cmd_pkg::PRM_SECOND:
            sensor_write_high_byte_o <= host_data_i;
          epd_cmd_pkg::PRM_THIRD: begin
            sensor_write_low_byte_o <= host_data_i;
            sensor_wr_req_o         <= powered_r;
            sensor_wr_bytes_o       <= 3'(attr_r[epd_cmd_pkg::CNT_MSB:
                                         epd_cmd_pkg::CNT_LSB]) + 3'h1;
            sensor_addr_bits_o      <= attr_r[epd_cmd_pkg::ADDR_MSB:
                                              epd_cmd_pkg::ADDR_LSB];
            sensor_pointer_o        <= attr_r[epd_cmd_pkg::PTR_MSB:0];
          end
          default: ;
        endcase
      end
    end
  end

endmodule

// ### design/epd_cmd_pkg.sv
// Constants shared by the display command decoder and its pixel selector.
// Assumes a single 10 MHz clock domain and byte-wide host transfers.
package epd_cmd_pkg;

  // ==========================================================================
  // Command codes.
  localparam logic [7:0] CMD_POWER_ON         = 8'h04;
  localparam logic [7:0] CMD_POWER_ON_MEASURE = 8'h05;
  localparam logic [7:0] CMD_PARTIAL_REFRESH  = 8'h16;
  localparam logic [7:0] CMD_LUT_FIRST        = 8'h20;
  localparam logic [7:0] CMD_LUT_LAST         = 8'h24;
  localparam logic [7:0] CMD_PLL              = 8'h30;
  localparam logic [7:0] CMD_TEMP_READ        = 8'h40;
  localparam logic [7:0] CMD_TEMP_CAL         = 8'h41;
  localparam logic [7:0] CMD_TEMP_WRITE       = 8'h42;

  // ==========================================================================
  // Parameter byte positions, counted from the first byte after a command.
  localparam logic [4:0] PRM_FIRST  = 5'h00;
  localparam logic [4:0] PRM_X_LO   = 5'h01;
  localparam logic [4:0] PRM_Y_HI   = 5'h02;
  localparam logic [4:0] PRM_Y_LO   = 5'h03;
  localparam logic [4:0] PRM_W_HI   = 5'h04;
  localparam logic [4:0] PRM_W_LO   = 5'h05;
  localparam logic [4:0] PRM_L_HI   = 5'h06;
  localparam logic [4:0] PRM_L_LO   = 5'h07;
  localparam logic [4:0] PRM_SECOND = 5'h01;
  localparam logic [4:0] PRM_THIRD  = 5'h02;
  localparam logic [4:0] PRM_SAT    = 5'h1f;

  // ==========================================================================
  // Field positions inside parameter bytes.
  localparam int DFV_BIT     = 7;
  localparam int HI_BIT      = 0;
  localparam int TSE_BIT     = 7;
  localparam int DIV_MSB     = 7;
  localparam int DIV_LSB     = 6;
  localparam int FREQ_MSB    = 5;
  localparam int CNT_MSB     = 7;
  localparam int CNT_LSB     = 6;
  localparam int ADDR_MSB    = 5;
  localparam int ADDR_LSB    = 3;
  localparam int PTR_MSB     = 2;
  localparam int OFFSET_MSB  = 3;

  // ==========================================================================
  // Reset values.
  localparam logic       TSE_RST    = 1'b0;
  localparam logic [3:0] OFFSET_RST = 4'h0;
  localparam logic [5:0] FREQ_RST   = 6'h00;
  localparam logic [1:0] DIV_RST    = 2'h0;

  // ==========================================================================
  // Look-up table storage.
  localparam int         LUT_COUNT = 5;
  localparam int         LUT_DEPTH = 16;
  localparam logic [4:0] LUT_LIMIT = 5'h10;

  // ==========================================================================
  // Frame clock: phase increment per cycle of a 32-bit accumulator.
  localparam longint CLK_HZ         = 10_000_000;
  localparam longint BASE_FRAME_MHZ = 156_250;
  localparam longint STEP_FRAME_MHZ = 2_758;
  localparam logic [31:0] INC_BASE =
    32'((64'd1 << 32) * BASE_FRAME_MHZ / (64'd1000 * CLK_HZ));
  localparam logic [31:0] INC_STEP =
    32'((64'd1 << 32) * STEP_FRAME_MHZ / (64'd1000 * CLK_HZ));

  // ==========================================================================
  // Waveform table codes and refresh states.
  typedef enum logic [2:0] {
    TBL_COMMON = 3'b000,
    TBL_WW     = 3'b001,
    TBL_BW     = 3'b010,
    TBL_WB     = 3'b011,
    TBL_BB     = 3'b100
  } table_type;

  typedef enum logic [1:0] {
    RF_IDLE  = 2'b00,
    RF_WAIT  = 2'b01,
    RF_SCAN  = 2'b10
  } refresh_type;

endpackage

// ### design/pixel_waveform_select.sv
// Picks the waveform table for one pixel during a refresh scan.
// Assumes new and old pixel bits are already valid for the pixel.
`timescale 1ns/100ps

module pixel_waveform_select (
  // Pixel context.
  input  wire logic                    in_area_i,
  input  wire logic                    follow_en_i,
  input  wire logic                    bw_mode_i,
  input  wire logic                    new_i,
  input  wire logic                    old_i,
  // Selected table.
  output epd_cmd_pkg::table_type       table_o
);

  // ==========================================================================
  // Selection
  // Outside the window the common-electrode waveform always wins.
  always_comb begin
    if (!in_area_i) begin
      table_o = epd_cmd_pkg::TBL_COMMON;
    end else if (follow_en_i && bw_mode_i && (new_i == old_i)) begin
      table_o = epd_cmd_pkg::TBL_COMMON;
    end else begin
      // Data-dependent table from the new and old pixel values.
      case ({new_i, old_i})
        2'b00:   table_o = epd_cmd_pkg::TBL_WW;
        2'b01:   table_o = epd_cmd_pkg::TBL_BW;
        2'b10:   table_o = epd_cmd_pkg::TBL_WB;
        2'b11:   table_o = epd_cmd_pkg::TBL_BB;
        default: table_o = epd_cmd_pkg::TBL_COMMON;
      endcase
    end
  end

endmodule

// ### tb/epd_cmd_props.sv
// Port checker for the display command decoder, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module epd_cmd_props (
  // Watched ports, grouped several to a line to keep the checker short.
  input wire logic       clk_i, nrst_i, ce_i, host_stb_i, host_cd_i,
  input wire logic       host_rw_i, host_rd_valid_o, busy_n_o, pix_valid_o,
  input wire logic       frame_tick_o, external_sensor_select_o,
  input wire logic       sensor_wr_req_o,
  input wire logic [2:0] pix_table_o, sensor_wr_bytes_o,
  input wire logic [3:0] temperature_offset_o
);
  // ==========================================================================
  // Strobed host bytes split by direction.
  wire logic rd_tk = ce_i && host_stb_i && host_cd_i && host_rw_i;
  wire logic pw_tk = ce_i && host_stb_i && host_cd_i && !host_rw_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  rd_answer_a: assert property (rd_tk |=> host_rd_valid_o)
    else $error("read strobe not answered");
  rd_cause_a: assert property (host_rd_valid_o |-> $past(rd_tk))
    else $error("read answer without a read strobe");
  req_pulse_a: assert property (sensor_wr_req_o |=> !sensor_wr_req_o)
    else $error("sensor request longer than one cycle");
  req_cause_a: assert property (sensor_wr_req_o |-> $past(pw_tk))
    else $error("sensor request not after a data byte");
  byte_count_a: assert property (sensor_wr_bytes_o inside {[1:4]})
    else $error("sensor byte count out of range");
  scan_busy_a: assert property (pix_valid_o |-> $past(!busy_n_o))
    else $error("pixel output outside a refresh");
  busy_start_a: assert property ($fell(busy_n_o) |-> $past(pw_tk))
    else $error("busy fell without a parameter byte");
  tick_pulse_a: assert property (frame_tick_o |=> !frame_tick_o)
    else $error("frame tick longer than one cycle");
  table_code_a: assert property (pix_valid_o |-> pix_table_o <= 3'h4)
    else $error("unknown table code");
  // A mid-run reset may clear the settings, hence the reset term.
  cal_hold_a: assert property ($past(nrst_i) && !$past(pw_tk) |->
    $stable({external_sensor_select_o, temperature_offset_o}))
    else $error("sensor settings changed without a write");
endmodule
bind epd_partial_refresh_pll_temp_cmds epd_cmd_props u_props (.*);

// ### tb/host_model.sv
// Host microcontroller model driving the byte port, one strobe per byte.
// Assumes the decoder samples the port on the rising edge of clk_i.
`timescale 1ns/100ps
module host_model (
  // Clock and host byte port.
  input  wire logic       clk_i,
  output logic            stb_o, cd_o, rw_o,
  output logic      [7:0] data_o
);
  initial begin
    stb_o = 1'b0;
    cd_o = 1'b0;
    rw_o = 1'b0;
    data_o = 8'h00;
  end
  // The byte is inverted on release so a stale value never looks fresh.
  task automatic send(input logic c, input logic r, input logic [7:0] v);
    @(posedge clk_i);
    stb_o <= 1'b1;
    cd_o <= c;
    rw_o <= r;
    data_o <= v;
    @(posedge clk_i);
    stb_o <= 1'b0;
    data_o <= ~v;
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the display command decoder.
// Assumes the host model owns the byte port; memory bits follow the scan.
`timescale 1ns/100ps
module tb_top;
  // ==========================================================================
  // Design ports, named alike so the instance connects by name.
  logic clk_i, nrst_i, ce_i, host_stb_i, host_cd_i, host_rw_i, bw_mode_i;
  logic pix_new_i, pix_old_i, host_rd_valid_o, busy_n_o, pix_valid_o;
  logic frame_tick_o, external_sensor_select_o, sensor_wr_req_o;
  logic [7:0] host_data_i, host_rd_data_o, lut_rd_data_o;
  logic [7:0] internal_temp_value_i;
  logic [7:0] sensor_write_high_byte_o, sensor_write_low_byte_o;
  logic [8:0] h_res_i, v_res_i, pix_x_o, pix_y_o;
  logic [2:0] pix_table_o, lut_rd_table_i, sensor_wr_bytes_o;
  logic [2:0] sensor_addr_bits_o, sensor_pointer_o;
  logic [3:0] lut_rd_index_i, temperature_offset_o;
  logic [10:0] ext_temp_i;
  logic [15:0] sum;
  int failures, n_tests, i, k;
  // Offset code beside the first read byte for an internal value of 20h.
  logic [11:0] rows [4] = '{12'h020, 12'h727, 12'h818, 12'hf1f};
  // Frame memory stand-in: the new bit is x[0], the old bit is y[0].
  assign pix_new_i = pix_x_o[0];
  assign pix_old_i = pix_y_o[0];
  epd_partial_refresh_pll_temp_cmds DUT (.*);
  host_model u_host (.clk_i, .stb_o(host_stb_i), .cd_o(host_cd_i),
                     .rw_o(host_rw_i), .data_o(host_data_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic c, input logic [7:0] v);
    u_host.send(c, 1'b0, v);
  endtask
  // Answer shows exactly one cycle after the strobe is taken.
  task automatic rd(input logic [7:0] exp);
    u_host.send(1'b1, 1'b1, 8'h00);
    @(negedge clk_i);
    chk({7'h00, host_rd_valid_o, host_rd_data_o}, {8'h01, exp});
  endtask
  initial begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    bw_mode_i = 1'b1;
    h_res_i = 9'h010;
    v_res_i = 9'h001;
    internal_temp_value_i = 8'h20;
    ext_temp_i = 11'h5a5;
    lut_rd_table_i = 3'h0;
    lut_rd_index_i = 4'h0;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    chk({busy_n_o, external_sensor_select_o, temperature_offset_o,
         sensor_wr_bytes_o}, 16'h0101);
    // A low clock enable must swallow a whole command and its parameter.
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(1'b0, 8'h41);
    wr(1'b1, 8'h8f);
    ce_i <= 1'b1;
    @(negedge clk_i);
    chk({11'h000, external_sensor_select_o, temperature_offset_o},
        16'h0000);
    for (i = 0; i < 4; i++) begin
      wr(1'b0, 8'h41);
      wr(1'b1, {4'h0, rows[i][11:8]});
      @(negedge clk_i);
      chk({12'h000, temperature_offset_o}, {12'h000, rows[i][11:8]});
      wr(1'b0, 8'h40);
      rd(rows[i][7:0]);
      rd(8'h00);
    end
    wr(1'b0, 8'h41);
    wr(1'b1, 8'h80);
    wr(1'b0, 8'h40);
    rd(8'hb4);
    rd(8'ha0);
    // First pass is unpowered; later passes cover every byte-count code.
    for (k = 0; k < 5; k++) begin
      if (k == 1) wr(1'b0, 8'h04);
      wr(1'b0, 8'h42);
      wr(1'b1, {k[1:0], 6'h15});
      wr(1'b1, 8'h12);
      wr(1'b1, 8'h34);
      @(negedge clk_i);
      chk({15'h0000, sensor_wr_req_o}, {15'h0000, k != 0});
      if (k != 0) begin
        chk({7'h00, sensor_wr_bytes_o, sensor_addr_bits_o, sensor_pointer_o},
            {7'h00, 3'(k[1:0] + 1), 3'h2, 3'h5});
        chk({sensor_write_high_byte_o, sensor_write_low_byte_o}, 16'h1234);
      end
    end
    for (k = 0; k < 5; k++) begin
      wr(1'b0, 8'h20 + 8'(k));
      wr(1'b1, 8'ha0 + 8'(k));
      wr(1'b1, 8'hb0 + 8'(k));
    end
    for (k = 0; k < 10; k++) begin
      @(posedge clk_i);
      lut_rd_table_i <= 3'(k / 2);
      lut_rd_index_i <= 4'(k % 2);
      @(posedge clk_i);
      @(negedge clk_i);
      chk({8'h00, lut_rd_data_o},
          {8'h00, (k[0] ? 8'hb0 : 8'ha0) + 8'(k / 2)});
    end
    // Window x 8..15 on one row of 16, X aligned to 8; the follow bit is set
    // on the first pass and clear on the second. The fastest frame code keeps
    // each wait well under one base frame period, so a lost PLL write times
    // out.
    wr(1'b0, 8'h30);
    wr(1'b1, 8'h1f);
    for (k = 0; k < 2; k++) begin
      wr(1'b0, 8'h16);
      for (i = 0; i < 8; i++) begin
        wr(1'b1, (i == 0) ? {~k[0], 7'h00} :
                 (i == 1 || i == 5) ? 8'h08 : 8'(i == 7));
      end
      @(negedge clk_i);
      chk({15'h0000, busy_n_o}, 16'h0000);
      sum = 16'h0000;
      for (i = 0; i < 45000 && !busy_n_o; i++) begin
        @(negedge clk_i);
        if (pix_valid_o) sum = sum + 16'h0100 + {13'h0000, pix_table_o};
      end
      if (busy_n_o) begin
        chk(sum, k[0] ? 16'h1010 : 16'h100c);
      end else begin
        failures++;
        k = 2;
      end
    end
    end_sim();
  end
endmodule
